// >>> rtl/sbsf_status.v
// status flag logic of the two-wire serial bus controller, with apb register slave
//
// What this block does
// RULE_01 - master tx: flag set on nack, cleared on ack
// RULE_02 - master tx busy flag: set at start, clear after ack
// RULE_03 - bus collision flag clears only by disable-reenable
// RULE_04 - general call flag set on match, cleared at stop
// RULE_05 - long address flag set on second byte match
// RULE_06 - tx holding write while busy fails, flags collision
// RULE_07 - new byte into full rx holding flags overflow
// RULE_08 - data flag cleared on address, set on data
// RULE_09 - stop flag tracks stop as last event
// RULE_10 - start flag tracks start as last event
// RULE_11 - direction flag loaded from slave address byte
// RULE_12 - rx full set on load, cleared by read
// RULE_13 - tx full set on write, cleared when sent
// RULE_14 - unimplemented bits read zero, flags reset zero
// RULE_15 - software clears clearable flags by writing zero
module sbsf_status (
   input  wire        clk,              // 40 MHz peripheral clock
   input  wire        sys_rst,          // synchronous reset, active high
   // apb slave
   input  wire        psel,             // slave select
   input  wire        penable,          // access phase
   input  wire        pwrite,           // 1 = write
   input  wire [7:0]  paddr,            // byte address
   input  wire [31:0] pwdata,           // write data
   output wire [31:0] prdata,           // read data, registered
   output wire        pready,           // always ready, no wait states
   output wire        pslverr,          // unmapped address
   // bus lines, observed only
   input  wire        scl_in,           // clock line level
   input  wire        sda_in,           // data line level
   // inputs from the bus engine, same clock; the events are one-cycle pulses
   input  wire        engine_busy,      // level: engine is moving a byte
   input  wire        mtx_begin,        // master transmission of a byte starts
   input  wire        slave_ack_end,    // end of slave acknowledge slot
   input  wire        slave_nacked,     // level with slave_ack_end: no ack
   input  wire        bus_collision,    // collision during master operation
   input  wire        gcall_match,      // general call address received
   input  wire        long_addr_match,  // second byte of long address matched
   input  wire        own_addr_match,   // device address matched
   input  wire        addr_read_bit,    // direction bit of the address byte
   input  wire        slave_data_rx,    // slave data byte received
   input  wire        rx_byte_done,     // shift register byte ready to move
   input  wire [7:0]  rx_shift_reg,     // byte in the receive shift register
   input  wire        tx_byte_sent,     // transmission of held byte completed
   // towards the bus engine
   output wire        module_on,        // module enable, from register
   output wire [7:0]  tx_holding_reg,   // byte to transmit, from register
   output wire        tx_holding_full,  // tx holding register loaded
   output wire        start_seen_pulse, // start or repeated start detected
   output wire        stop_seen_pulse   // stop detected
);
`include "sbsf_consts.vh"

   ////////////////////////////////////////////////////////////////////////////
   // register storage

   reg        on_q;        // module enable
   reg        on_d;        // next module enable
   reg        on_prev_q;   // enable last cycle, for re-enable edge
   reg [7:0]  tx_q;        // tx holding register
   reg [7:0]  rx_q;        // rx holding register
   reg [31:0] rdata_q;     // read data captured in setup phase
   reg [31:0] rdata_d;     // read mux
   reg        scl_prev_q;  // filtered clock line last cycle
   reg        sda_prev_q;  // filtered data line last cycle

   wire        scl_lvl;     // synchronised clock line
   wire        sda_lvl;     // synchronised data line
   wire [31:0] status_word; // assembled status image

   // flag levels
   wire nack_received_flag;
   wire master_tx_active;
   wire bus_collision_flag;
   wire general_call_seen;
   wire long_address_matched;
   wire write_collision_flag;
   wire receive_overflow_flag;
   wire data_not_addr;
   wire stop_last;
   wire start_last;
   wire slave_read_dir;
   wire rx_holding_full;
   wire tx_full;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   wire setup_ph  = psel & ~penable;              // first cycle of a transfer
   wire access_ph = psel & penable;               // completes at once
   wire wr_acc    = access_ph & pwrite;           // write takes effect here
   wire rd_acc    = access_ph & ~pwrite;          // read completes here

   wire hit_ctrl   = (paddr == `SBSF_OFF_CTRL);
   wire hit_status = (paddr == `SBSF_OFF_STATUS);
   wire hit_tx     = (paddr == `SBSF_OFF_TXHOLD);
   wire hit_rx     = (paddr == `SBSF_OFF_RXHOLD);
   wire hit_any    = hit_ctrl | hit_status | hit_tx | hit_rx;

   // zero wait states keep the slave simple; the cost is that read data
   // shows the state as of the setup edge, one cycle before completion
   assign pready  = 1'b1;
   assign pslverr = access_ph & ~hit_any;

   // software effects of register accesses
   wire tx_write  = wr_acc & hit_tx;
   wire tx_ok     = tx_write & ~engine_busy;      // RULE_06
   wire tx_fail   = tx_write & engine_busy;       // RULE_06
   wire rx_read   = rd_acc & hit_rx;              // RULE_12
   wire st_write  = wr_acc & hit_status;
   wire wcol_clr  = st_write & ~pwdata[`SBSF_B_WCOL]; // RULE_15
   wire rov_clr   = st_write & ~pwdata[`SBSF_B_ROV];  // RULE_15

   ////////////////////////////////////////////////////////////////////////////
   // control register and enable edge

   // next enable comes only from a control write
   always @* begin
      on_d = on_q;
      if (wr_acc && hit_ctrl) begin
         on_d = pwdata[`SBSF_CTRL_ON];
      end
   end

   // the enable steers every engine and bus line event; events while off are dropped
   always @(posedge clk) begin
      if (sys_rst) begin
         on_q      <= `SBSF_CTRL_RST;
         on_prev_q <= `SBSF_CTRL_RST;
      end else begin
         on_q      <= on_d;
         on_prev_q <= on_q;
      end
   end

   assign module_on = on_q;

   // rising edge of the enable ends a collision episode
   wire reenable = on_q & ~on_prev_q;             // RULE_03

   ////////////////////////////////////////////////////////////////////////////
   // gated engine events; declared here because the rx holding register reads ev_rx

   wire ev_ack   = on_q & slave_ack_end;
   wire ev_rx    = on_q & rx_byte_done;
   wire ev_addr  = on_q & own_addr_match;

   ////////////////////////////////////////////////////////////////////////////
   // holding registers

   // tx byte loads only on a write that does not collide; rx byte loads
   // only into an empty register so the unread byte survives an overflow
   always @(posedge clk) begin
      if (sys_rst) begin
         tx_q <= `SBSF_BYTE_RST;
         rx_q <= `SBSF_BYTE_RST;
      end else begin
         if (tx_ok) begin
            tx_q <= pwdata[7:0];                  // RULE_06
         end
         if (ev_rx && !rx_holding_full) begin
            rx_q <= rx_shift_reg;                 // RULE_07
         end
      end
   end

   assign tx_holding_reg = tx_q;

   ////////////////////////////////////////////////////////////////////////////
   // start and stop detection on the bus lines

   sbsf_sync3 u_sync_scl (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin_in  (scl_in),
      .level   (scl_lvl)
   );

   sbsf_sync3 u_sync_sda (
      .clk     (clk),
      .sys_rst (sys_rst),
      .pin_in  (sda_in),
      .level   (sda_lvl)
   );

   // previous filtered levels for edge detection
   always @(posedge clk) begin
      if (sys_rst) begin
         scl_prev_q <= `SBSF_LINE_IDLE;
         sda_prev_q <= `SBSF_LINE_IDLE;
      end else begin
         scl_prev_q <= scl_lvl;
         sda_prev_q <= sda_lvl;
      end
   end

   // data line moving while the clock line stays high marks a condition
   wire scl_steady_hi = scl_lvl & scl_prev_q;
   wire ev_start = on_q & scl_steady_hi & sda_prev_q & ~sda_lvl;
   wire ev_stop  = on_q & scl_steady_hi & ~sda_prev_q & sda_lvl;

   assign start_seen_pulse = ev_start;
   assign stop_seen_pulse  = ev_stop;

   ////////////////////////////////////////////////////////////////////////////
   // flags

   // acknowledge outcome, rewritten at every slave acknowledge
   sbsf_flag u_nack (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (ev_ack & slave_nacked),           // RULE_01
      .clr     (ev_ack & ~slave_nacked),          // RULE_01
      .q       (nack_received_flag)
   );

   // byte plus acknowledge in flight
   sbsf_flag u_mtx (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (on_q & mtx_begin),                // RULE_02
      .clr     (ev_ack),                          // RULE_02
      .q       (master_tx_active)
   );

   // software cannot clear this one; only a disable then enable does
   sbsf_flag u_bcol (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (on_q & bus_collision),            // RULE_03
      .clr     (reenable),                        // RULE_03
      .q       (bus_collision_flag)
   );

   sbsf_flag u_gcall (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (on_q & gcall_match),              // RULE_04
      .clr     (ev_stop),                         // RULE_04
      .q       (general_call_seen)
   );

   sbsf_flag u_laddr (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (on_q & long_addr_match),          // RULE_05
      .clr     (ev_stop),                         // RULE_05
      .q       (long_address_matched)
   );

   // a failed tx write leaves the holding register untouched
   sbsf_flag u_wcol (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (tx_fail),                         // RULE_06
      .clr     (wcol_clr),                        // RULE_15
      .q       (write_collision_flag)
   );

   sbsf_flag u_rov (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (ev_rx & rx_holding_full),         // RULE_07
      .clr     (rov_clr),                         // RULE_15
      .q       (receive_overflow_flag)
   );

   // last slave byte was data (1) or own address (0)
   sbsf_flag u_data (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (on_q & slave_data_rx),            // RULE_08
      .clr     (ev_addr),                         // RULE_08
      .q       (data_not_addr)
   );

   // start and stop flags mirror each other; both zero until first event
   sbsf_flag u_stop (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (ev_stop),                         // RULE_09
      .clr     (ev_start),                        // RULE_09
      .q       (stop_last)
   );

   sbsf_flag u_start (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (ev_start),                        // RULE_10
      .clr     (ev_stop),                         // RULE_10
      .q       (start_last)
   );

   // direction loaded from the address byte's last bit
   sbsf_flag u_dir (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (ev_addr & addr_read_bit),         // RULE_11
      .clr     (ev_addr & ~addr_read_bit),        // RULE_11
      .q       (slave_read_dir)
   );

   // a byte arriving as software reads a full register is dropped; the flag clears and overflow sets
   sbsf_flag u_rxfull (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (ev_rx & ~rx_holding_full),        // RULE_12
      .clr     (rx_read),                         // RULE_12
      .q       (rx_holding_full)
   );

   sbsf_flag u_txfull (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (tx_ok),                           // RULE_13
      .clr     (on_q & tx_byte_sent),             // RULE_13
      .q       (tx_full)
   );

   assign tx_holding_full = tx_full;

   ////////////////////////////////////////////////////////////////////////////
   // status image; unimplemented bits are hard zero

   assign status_word = {16'h0000,                // RULE_14
                         nack_received_flag,
                         master_tx_active,
                         3'h0,                    // RULE_14
                         bus_collision_flag,
                         general_call_seen,
                         long_address_matched,
                         write_collision_flag,
                         receive_overflow_flag,
                         data_not_addr,
                         stop_last,
                         start_last,
                         slave_read_dir,
                         rx_holding_full,
                         tx_full};

   ////////////////////////////////////////////////////////////////////////////
   // read path

   // read mux, unmapped addresses read zero
   always @* begin
      rdata_d = `SBSF_WORD_ZERO;
      case (1'b1)
         hit_ctrl: begin
            rdata_d[`SBSF_CTRL_ON] = on_q;
         end
         hit_status: begin
            rdata_d = status_word;
         end
         hit_tx: begin
            rdata_d[7:0] = tx_q;
         end
         hit_rx: begin
            rdata_d[7:0] = rx_q;
         end
         default: begin
            rdata_d = `SBSF_WORD_ZERO;
         end
      endcase
   end

   // captured at the setup edge so prdata is a flop during access
   always @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= `SBSF_WORD_ZERO;
      end else if (setup_ph && !pwrite) begin
         rdata_q <= rdata_d;
      end
   end

   assign prdata = rdata_q;

endmodule // sbsf_status

// >>> rtl/sbsf_consts.vh
// constants for the serial bus status flag block: offsets, bit positions, reset values
`ifndef SBSF_CONSTS_VH
`define SBSF_CONSTS_VH

// register byte offsets on the apb slave
`define SBSF_OFF_CTRL      8'h00
`define SBSF_OFF_STATUS    8'h04
`define SBSF_OFF_TXHOLD    8'h08
`define SBSF_OFF_RXHOLD    8'h0C
`define SBSF_ADDR_W        8

// control register fields
`define SBSF_CTRL_ON       15
`define SBSF_CTRL_RST      1'h0

// status register bit positions
`define SBSF_B_NACK        15
`define SBSF_B_MTX         14
`define SBSF_B_BCOL        10
`define SBSF_B_GCALL       9
`define SBSF_B_LADDR       8
`define SBSF_B_WCOL        7
`define SBSF_B_ROV         6
`define SBSF_B_DATA        5
`define SBSF_B_STOP        4
`define SBSF_B_START       3
`define SBSF_B_READ        2
`define SBSF_B_RXFULL      1
`define SBSF_B_TXFULL      0

// reset values
`define SBSF_FLAG_RST      1'h0
`define SBSF_BYTE_RST      8'h00
`define SBSF_WORD_ZERO     32'h00000000
`define SBSF_LINE_IDLE     1'h1

`endif

// >>> rtl/sbsf_sync3.v
// three-flop pin synchroniser that accepts a change once stages two and three agree
module sbsf_sync3 (
   input  wire clk,       // peripheral clock
   input  wire sys_rst,   // synchronous reset, active high
   input  wire pin_in,    // raw pin level from outside the clock domain
   output wire level      // filtered, synchronised level
);
`include "sbsf_consts.vh"

   ////////////////////////////////////////////////////////////////////////////
   reg s1_q;      // first stage, read only by the second
   reg s2_q;      // second stage
   reg s3_q;      // third stage
   reg level_q;   // accepted level

   // shift chain; bus lines idle high so reset to high
   always @(posedge clk) begin
      if (sys_rst) begin
         s1_q    <= `SBSF_LINE_IDLE;
         s2_q    <= `SBSF_LINE_IDLE;
         s3_q    <= `SBSF_LINE_IDLE;
         level_q <= `SBSF_LINE_IDLE;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // a single-cycle glitch never reaches level_q
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign level = level_q;

endmodule // sbsf_sync3

// >>> rtl/sbsf_flag.v
// one status flag with hardware set, hardware or software clear, set winning
module sbsf_flag (
   input  wire clk,       // peripheral clock
   input  wire sys_rst,   // synchronous reset, active high
   input  wire set,       // set request, one cycle
   input  wire clr,       // clear request, one cycle
   output wire q          // flag level
);
`include "sbsf_consts.vh"

   ////////////////////////////////////////////////////////////////////////////
   reg q_q;   // flag storage

   // set beats clear so an event in the clear cycle is not lost
   always @(posedge clk) begin
      if (sys_rst) begin
         q_q <= `SBSF_FLAG_RST;
      end else if (set) begin
         q_q <= 1'b1;
      end else if (clr) begin
         q_q <= 1'b0;
      end
   end

   assign q = q_q;

endmodule // sbsf_flag

// >>> tb/sbsf_status_checker.sv
// concurrent checks on the ports of the serial bus status flag block
`include "sbsf_consts.vh"
module sbsf_status_checker (
   input logic        clk,
   input logic        sys_rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        engine_busy,
   input logic        mtx_begin,
   input logic        slave_ack_end,
   input logic        slave_nacked,
   input logic        bus_collision,
   input logic        gcall_match,
   input logic        long_addr_match,
   input logic        own_addr_match,
   input logic        addr_read_bit,
   input logic        slave_data_rx,
   input logic        rx_byte_done,
   input logic        tx_byte_sent,
   input logic        module_on,
   input logic [7:0]  tx_holding_reg,
   input logic        tx_holding_full
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic txw; // access phase of a tx holding write
   assign txw = psel && penable && pwrite && paddr == `SBSF_OFF_TXHOLD;
   ////////////////////////////////////////////////////////////////////////////
   // setup cycle of a status read; prdata is loaded at its edge
   sequence st_rd;
      psel && !penable && !pwrite && paddr == `SBSF_OFF_STATUS;
   endsequence
   // an engine event must show in the status word read right after it
   property p_seen(ev, b, v);
      (ev && module_on) ##1 st_rd |=> prdata[b] == v;
   endproperty
   a_nack_set:
   assert property (p_seen(slave_ack_end && slave_nacked, `SBSF_B_NACK, 1'b1))
      else $error("nack flag not set");
   a_ack_clear:
   assert property (p_seen(slave_ack_end && !slave_nacked, `SBSF_B_NACK, 1'b0))
      else $error("nack flag not cleared");
   a_mtx_busy:
   assert property (p_seen(mtx_begin, `SBSF_B_MTX, 1'b1))
      else $error("master tx flag not set");
   a_mtx_done:
   assert property (p_seen(slave_ack_end && !mtx_begin, `SBSF_B_MTX, 1'b0))
      else $error("master tx flag not cleared");
   a_coll_seen:
   assert property (p_seen(bus_collision, `SBSF_B_BCOL, 1'b1))
      else $error("collision flag not set");
   a_gcall_seen:
   assert property (p_seen(gcall_match, `SBSF_B_GCALL, 1'b1))
      else $error("general call flag not set");
   a_long_addr:
   assert property (p_seen(long_addr_match, `SBSF_B_LADDR, 1'b1))
      else $error("long address flag not set");
   a_addr_byte:
   assert property (p_seen(own_addr_match && !slave_data_rx, `SBSF_B_DATA, 1'b0))
      else $error("data flag not cleared on address");
   a_data_byte:
   assert property (p_seen(slave_data_rx, `SBSF_B_DATA, 1'b1))
      else $error("data flag not set on data");
   a_dir_read:
   assert property (p_seen(own_addr_match && addr_read_bit, `SBSF_B_READ, 1'b1))
      else $error("direction flag not read");
   a_rx_load:
   assert property (p_seen(rx_byte_done, `SBSF_B_RXFULL, 1'b1))
      else $error("rx full flag not set");
   // a refused write must leave the held byte untouched
   a_tx_refused:
   assert property (txw && engine_busy && module_on |=> $stable(tx_holding_reg))
      else $error("busy tx write changed held byte");
   a_tx_loaded:
   assert property (txw && !engine_busy |=>
      tx_holding_full && tx_holding_reg == $past(pwdata[7:0]))
      else $error("tx write not loaded");
   a_tx_sent:
   assert property (tx_byte_sent && module_on && !txw |=> !tx_holding_full)
      else $error("tx full not cleared when sent");
   a_upper_zero:
   assert property (st_rd |=> prdata[31:16] == 16'h0000 && prdata[13:11] == 3'h0)
      else $error("unimplemented status bits not zero");
endmodule // sbsf_status_checker

// >>> tb/sbsf_bus_partner.sv
// model of the other two-wire bus devices, making start and stop conditions
module sbsf_bus_partner (
   input  logic clk,  // pacing clock
   output logic scl,  // clock line, pulled up when released
   output logic sda   // data line, pulled up when released
);
   timeunit 1ns;
   timeprecision 1ps;
   // released lines sit at the pull-up level
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // hold a level pair long enough to pass the three-flop filter
   task automatic hold(input logic c, input logic d);
      scl <= c;
      sda <= d;
      repeat (6) @(posedge clk);
   endtask
   // start: data falls with clock high; stop: data rises with clock high
   task automatic frame(input logic stop);
      if (stop) begin
         hold(1'b0, 1'b0);
         hold(1'b1, 1'b0);
         hold(1'b1, 1'b1);
      end else begin
         hold(1'b1, 1'b1);
         hold(1'b1, 1'b0);
         hold(1'b0, 1'b0); // clock held low, frame open
      end
   endtask
endmodule // sbsf_bus_partner

// >>> tb/test_i2c_status_flag_logic.sv
// self-checking bench for the serial bus status flag block
`include "sbsf_consts.vh"
module test_i2c_status_flag_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, sys_rst;             // clock and reset
   logic        psel, penable, pwrite;    // apb control
   logic [7:0]  paddr;                    // apb address
   logic [31:0] pwdata, prdata, rd, exp;  // apb data, last read, expected status
   logic        pready, pslverr, err;     // apb answer
   logic        on, start_p, stop_p;      // enable and condition pulses seen
   logic        scl, sda;                 // bus lines from the partner
   logic [8:0]  ev;                       // engine event pulses
   logic        engine_busy, slave_nacked, addr_read_bit;
   logic [7:0]  rx_shift_reg;             // byte offered by the engine
   int          num_errors, comparisons, cycles, n_start, n_stop;
   sbsf_status uut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
      .engine_busy(engine_busy), .mtx_begin(ev[0]), .slave_ack_end(ev[1]),
      .slave_nacked(slave_nacked), .bus_collision(ev[2]), .gcall_match(ev[3]),
      .long_addr_match(ev[4]), .own_addr_match(ev[5]),
      .addr_read_bit(addr_read_bit), .slave_data_rx(ev[6]),
      .rx_byte_done(ev[7]), .rx_shift_reg(rx_shift_reg), .tx_byte_sent(ev[8]),
      .module_on(on), .tx_holding_reg(), .tx_holding_full(),
      .start_seen_pulse(start_p), .stop_seen_pulse(stop_p));
   sbsf_bus_partner bus (.clk(clk), .scl(scl), .sda(sda));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // cut a hang short; the whole run needs well under a thousand cycles;
   // also count the start and stop pulses the block reports
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (start_p === 1'b1) n_start++;
      if (stop_p === 1'b1) n_stop++;
      if (cycles == 5000) begin
         num_errors++;
         close_out();
      end
   end
   // one apb transfer; waits for pready, never assumes a latency
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic st(input logic [31:0] e);
      apb(1'b0, `SBSF_OFF_STATUS, 32'h00000000);
      chk("status", e, rd);
   endtask
   // pulse events, update the expected flags, read status straight after
   task automatic ev_chk(input logic [8:0] m, input logic [31:0] s, input logic [31:0] c);
      ev <= m;
      @(posedge clk);
      ev <= 9'h000;
      exp = (exp & ~c) | s;
      st(exp);
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ev, rx_shift_reg} = '0;
      {engine_busy, slave_nacked, addr_read_bit} = '0;
      {num_errors, comparisons, cycles, exp, n_start, n_stop} = '0;
      sys_rst = 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      st(exp);
      apb(1'b0, 8'h10, 32'h00000000);
      chk("unmapped", 32'h00000001, {rd[30:0], err});
      apb(1'b1, `SBSF_OFF_CTRL, 32'h00008000);
      chk("module on", 32'h00000001, {31'h00000000, on});
      ev_chk(9'h001, 32'h00004000, 32'h0);
      slave_nacked <= 1'b1;
      ev_chk(9'h002, 32'h00008000, 32'h00004000);
      slave_nacked <= 1'b0;
      ev_chk(9'h002, 32'h0, 32'h00008000);
      ev_chk(9'h008, 32'h00000200, 32'h0);
      ev_chk(9'h010, 32'h00000100, 32'h0);
      addr_read_bit <= 1'b1;
      ev_chk(9'h020, 32'h00000004, 32'h00000020);
      ev_chk(9'h040, 32'h00000020, 32'h0);
      addr_read_bit <= 1'b0;
      ev_chk(9'h020, 32'h0, 32'h00000024);
      bus.frame(1'b0);
      ev_chk(9'h000, 32'h00000008, 32'h00000010);
      chk("start pulses", 32'h00000001, n_start);
      bus.frame(1'b1);
      ev_chk(9'h000, 32'h00000010, 32'h00000308);
      chk("stop pulses", 32'h00000001, n_stop);
      ev_chk(9'h004, 32'h00000400, 32'h0);
      rx_shift_reg <= 8'hA5;
      ev_chk(9'h080, 32'h00000002, 32'h0);
      rx_shift_reg <= 8'h3C;
      ev_chk(9'h080, 32'h00000040, 32'h0);
      apb(1'b0, `SBSF_OFF_RXHOLD, 32'h00000000);
      chk("rx hold", 32'h000000A5, rd);
      ev_chk(9'h000, 32'h0, 32'h00000002);
      apb(1'b1, `SBSF_OFF_STATUS, 32'hFFFFFFFF);
      ev_chk(9'h000, 32'h0, 32'h0);
      apb(1'b1, `SBSF_OFF_STATUS, 32'h00000000);
      ev_chk(9'h000, 32'h0, 32'h00000040);
      apb(1'b1, `SBSF_OFF_TXHOLD, 32'h0000005A);
      ev_chk(9'h000, 32'h00000001, 32'h0);
      engine_busy <= 1'b1;
      apb(1'b1, `SBSF_OFF_TXHOLD, 32'h00000077);
      ev_chk(9'h000, 32'h00000080, 32'h0);
      engine_busy <= 1'b0;
      apb(1'b0, `SBSF_OFF_TXHOLD, 32'h00000000);
      chk("tx hold", 32'h0000005A, rd);
      ev_chk(9'h100, 32'h0, 32'h00000001);
      apb(1'b1, `SBSF_OFF_STATUS, 32'hFFFFFF7F);
      ev_chk(9'h000, 32'h0, 32'h00000080);
      apb(1'b1, `SBSF_OFF_CTRL, 32'h00000000);
      chk("module off", 32'h00000000, {31'h00000000, on});
      ev_chk(9'h008, 32'h0, 32'h0);
      apb(1'b1, `SBSF_OFF_CTRL, 32'h00008000);
      ev_chk(9'h000, 32'h0, 32'h00000400);
      close_out();
   end
endmodule // test_i2c_status_flag_logic

bind sbsf_status sbsf_status_checker chk_i (.clk, .sys_rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .engine_busy, .mtx_begin, .slave_ack_end,
   .slave_nacked, .bus_collision, .gcall_match, .long_addr_match, .own_addr_match,
   .addr_read_bit, .slave_data_rx, .rx_byte_done, .tx_byte_sent, .module_on,
   .tx_holding_reg, .tx_holding_full);
